// File: design/dpagc_top.sv
// Driver power-down status, pop sequencing and AGC limit registers
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
module dpagc_top #(
    parameter int HALF_MS_CYCLES = dpagc_pkg::HALF_MS_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_short_detect,
    input  wire logic        i_mic_below_thr,
    input  wire logic        i_cell_below_thr,
    input  wire logic [6:0]  i_mic_gain_req,
    input  wire logic [6:0]  i_cell_gain_req,
    output logic      [6:0]  o_mic_gain,
    output logic      [6:0]  o_cell_gain,
    output logic             o_mic_silence,
    output logic             o_cell_silence,
    output logic      [5:0]  o_drv_enable,
    output logic             o_pop_busy
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic {POP_IDLE, POP_RUN} dpagc_pop_e;

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        sync3;
        logic        short_q;
        logic        pop_dis;
        logic        pop_len;
        logic [6:0]  mic_cap;
        logic [2:0]  mic_ns;
        logic [2:0]  mic_sn;
        logic [6:0]  cell_cap;
        logic [2:0]  cell_ns;
        logic [2:0]  cell_sn;
        logic [8:0]  ctrl;
        dpagc_pop_e  pop_st;
        logic [13:0] pop_cnt;
        logic [5:0]  granted;
        logic [5:0]  drv_on;
        logic [15:0] tick_cnt;
        logic        tick;
    } dpagc_top_s;

    localparam logic [15:0] TICK_LAST = 16'(HALF_MS_CYCLES - 1);

    dpagc_top_s st_reg;
    dpagc_top_s st_next;

    dpagc_reg_if rif ();

    logic [5:0]  req;
    logic [5:0]  flags;
    logic [5:0]  seq_pending;
    logic [13:0] pop_ticks;
    logic        mic_silence;
    logic        cell_silence;

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    dpagc_ahb_slave u_slave (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_hsel      (i_hsel),
        .i_haddr     (i_haddr),
        .i_htrans    (i_htrans),
        .i_hwrite    (i_hwrite),
        .i_hwdata    (i_hwdata),
        .i_hready    (i_hready),
        .o_hrdata    (o_hrdata),
        .o_hreadyout (o_hreadyout),
        .bus         (rif.slave)
    );

    // Only word transfers are used, so size plays no part in decode
    assign o_hresp = 1'b0;

    // ---------------------------------------------------------------
    // Derived control
    // ---------------------------------------------------------------
    // Driver power requests come from the control register
    assign req = st_reg.ctrl[dpagc_pkg::CTRL_REQ_HI:0];

    // A driver reads powered down whenever it is not driving
    assign flags = ~st_reg.drv_on; // RULE2

    // Sequenced drivers asked for but not yet through the sequence
    assign seq_pending = req & dpagc_pkg::SEQ_MASK & ~st_reg.granted;

    // Long sequence only for speakers in cap-coupled mode
    always_comb
    begin
        pop_ticks = dpagc_pkg::POP_CAPLESS_TICKS;
        if (st_reg.ctrl[dpagc_pkg::CTRL_CAP_MODE]
            && |(seq_pending & dpagc_pkg::SPK_MASK))
        begin
            pop_ticks = st_reg.pop_len ? dpagc_pkg::POP_LONG_TICKS
                                       : dpagc_pkg::POP_SHORT_TICKS; // RULE5
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    // Reserved bits are held at zero here, whatever was written
    always_comb
    begin
        rif.rdata = 16'h0000;
        rif.hit = 1'b1;
        unique case (rif.idx)
            dpagc_pkg::IDX_DRV_STATUS:
            begin
                rif.rdata[dpagc_pkg::FLAG_HI:dpagc_pkg::FLAG_LO] = flags; // RULE2
                rif.rdata[dpagc_pkg::POP_DIS_BIT] = st_reg.pop_dis;
                rif.rdata[dpagc_pkg::POP_LEN_BIT] = st_reg.pop_len; // RULE3
            end
            dpagc_pkg::IDX_MIC_LIMITS:
            begin
                rif.rdata[dpagc_pkg::CAP_HI:dpagc_pkg::CAP_LO] = st_reg.mic_cap;
                rif.rdata[dpagc_pkg::NS_HI:dpagc_pkg::NS_LO] = st_reg.mic_ns;
                rif.rdata[dpagc_pkg::SN_HI:dpagc_pkg::SN_LO] = st_reg.mic_sn;
            end
            dpagc_pkg::IDX_CELL_LIMITS:
            begin
                rif.rdata[dpagc_pkg::CAP_HI:dpagc_pkg::CAP_LO] = st_reg.cell_cap;
                rif.rdata[dpagc_pkg::NS_HI:dpagc_pkg::NS_LO] = st_reg.cell_ns;
                rif.rdata[dpagc_pkg::SN_HI:dpagc_pkg::SN_LO] = st_reg.cell_sn;
            end
            dpagc_pkg::IDX_CTRL:
            begin
                rif.rdata[8:0] = st_reg.ctrl;
            end
            dpagc_pkg::IDX_STATE:
            begin
                rif.rdata[0] = st_reg.short_q; // RULE1
                rif.rdata[1] = (st_reg.pop_st == POP_RUN);
                rif.rdata[2] = mic_silence;
                rif.rdata[3] = cell_silence;
            end
            default:
            begin
                rif.hit = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;

        // Short input crosses in; a change counts when two stages agree
        st_next.sync1 = i_short_detect;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        if (st_reg.sync2 == st_reg.sync3)
            st_next.short_q = st_reg.sync3;

        // Half-millisecond enable for sequencing and debounce
        st_next.tick = 1'b0;
        if (st_reg.tick_cnt == TICK_LAST)
        begin
            st_next.tick_cnt = 16'h0000;
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
        end

        // Register writes; reserved bits are simply not stored
        if (rif.wr)
        begin
            unique case (rif.idx)
                dpagc_pkg::IDX_DRV_STATUS:
                begin
                    st_next.pop_dis = rif.wdata[dpagc_pkg::POP_DIS_BIT];
                    st_next.pop_len = rif.wdata[dpagc_pkg::POP_LEN_BIT];
                end
                dpagc_pkg::IDX_MIC_LIMITS:
                begin
                    st_next.mic_cap = rif.wdata[dpagc_pkg::CAP_HI:dpagc_pkg::CAP_LO];
                    st_next.mic_ns = rif.wdata[dpagc_pkg::NS_HI:dpagc_pkg::NS_LO];
                    st_next.mic_sn = rif.wdata[dpagc_pkg::SN_HI:dpagc_pkg::SN_LO];
                end
                dpagc_pkg::IDX_CELL_LIMITS:
                begin
                    st_next.cell_cap = rif.wdata[dpagc_pkg::CAP_HI:dpagc_pkg::CAP_LO];
                    st_next.cell_ns = rif.wdata[dpagc_pkg::NS_HI:dpagc_pkg::NS_LO];
                    st_next.cell_sn = rif.wdata[dpagc_pkg::SN_HI:dpagc_pkg::SN_LO];
                end
                dpagc_pkg::IDX_CTRL:
                begin
                    st_next.ctrl = rif.wdata[8:0];
                end
                default:
                begin
                end
            endcase
        end

        // Dropping a request forgets the completed sequence
        st_next.granted = st_reg.granted & req;

        // Pop sequencer
        unique case (st_reg.pop_st)
            POP_IDLE:
            begin
                if (st_reg.pop_dis)
                begin
                    st_next.granted = req & dpagc_pkg::SEQ_MASK; // RULE4
                end
                else if (|seq_pending && !st_reg.short_q)
                begin
                    st_next.pop_cnt = pop_ticks; // RULE4 RULE5
                    st_next.pop_st = POP_RUN;
                end
            end
            POP_RUN:
            begin
                // A short, or withdrawal of every pending sequenced request, abandons the sequence
                if (st_reg.short_q || ~|seq_pending)
                begin
                    st_next.pop_st = POP_IDLE;
                end
                else if (st_reg.pop_cnt == 14'h0000)
                begin
                    st_next.granted = req & dpagc_pkg::SEQ_MASK; // RULE4
                    st_next.pop_st = POP_IDLE;
                end
                else if (st_reg.tick)
                begin
                    st_next.pop_cnt = st_reg.pop_cnt - 14'h0001;
                end
            end
        endcase

        // Drivers: unsequenced ones follow the request directly.
        // A short drops every driver, so flags then carry no meaning.
        st_next.drv_on = req & (~dpagc_pkg::SEQ_MASK | st_next.granted);
        if (st_reg.short_q)
            st_next.drv_on = 6'h00; // RULE1
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '{
                sync1: 1'b0,
                sync2: 1'b0,
                sync3: 1'b0,
                short_q: 1'b0,
                pop_dis: 1'b0,
                pop_len: 1'b0,
                mic_cap: dpagc_pkg::CAP_RST,
                mic_ns: dpagc_pkg::DEB_RST,
                mic_sn: dpagc_pkg::DEB_RST,
                cell_cap: dpagc_pkg::CAP_RST,
                cell_ns: dpagc_pkg::DEB_RST,
                cell_sn: dpagc_pkg::DEB_RST,
                ctrl: dpagc_pkg::CTRL_RST,
                pop_st: POP_IDLE,
                pop_cnt: 14'h0000,
                granted: 6'h00,
                drv_on: ~dpagc_pkg::FLAGS_RST,
                tick_cnt: 16'h0000,
                tick: 1'b0
            };
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // AGC paths
    // ---------------------------------------------------------------
    // Microphone path
    dpagc_agc_path #(
        .CELL (1'b0)
    ) u_mic (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_tick     (st_reg.tick),
        .i_below    (i_mic_below_thr),
        .i_enable   (st_reg.ctrl[dpagc_pkg::CTRL_MIC_EN]),
        .i_cap      (st_reg.mic_cap),
        .i_ns_code  (st_reg.mic_ns),
        .i_sn_code  (st_reg.mic_sn),
        .i_gain_req (i_mic_gain_req),
        .o_gain     (o_mic_gain),
        .o_silence  (mic_silence)
    );

    // Cell-phone input path, with its own cap encoding
    dpagc_agc_path #(
        .CELL (1'b1)
    ) u_cell (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_tick     (st_reg.tick),
        .i_below    (i_cell_below_thr),
        .i_enable   (st_reg.ctrl[dpagc_pkg::CTRL_CELL_EN]),
        .i_cap      (st_reg.cell_cap),
        .i_ns_code  (st_reg.cell_ns),
        .i_sn_code  (st_reg.cell_sn),
        .i_gain_req (i_cell_gain_req),
        .o_gain     (o_cell_gain),
        .o_silence  (cell_silence)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign o_mic_silence = mic_silence;
    assign o_cell_silence = cell_silence;
    assign o_drv_enable = st_reg.drv_on;
    assign o_pop_busy = (st_reg.pop_st == POP_RUN);
endmodule

// File: design/dpagc_pkg.sv
// Constants shared by the driver status and AGC limit register block
//
// Overview of operation
// (RULE1) Status flags meaningful only without a short
// (RULE2) Six driver off flags, set at reset
// (RULE3) Reserved fields written zero, read zero
// (RULE4) Bit five low applies driver pop sequencing
// (RULE5) Bit four picks 802 or 4006 ms
// (RULE6) Mic gain cap, 0.5 dB steps, resets all ones
// (RULE7) Mic enters silence after below-threshold debounce
// (RULE8) Mic leaves silence after its own debounce
// (RULE9) Cell cap code map with invalid band
// (RULE10) Cell enters silence after its debounce time
// (RULE11) Cell leaves silence after its debounce time
// (RULE12) Enabled AGC gain never exceeds programmed cap
package dpagc_pkg;
    // ----------------
    // Register indices, byte address is four times the index
    // ----------------
    localparam logic [7:0] IDX_DRV_STATUS = 8'h25;
    localparam logic [7:0] IDX_MIC_LIMITS = 8'h26;
    localparam logic [7:0] IDX_CELL_LIMITS = 8'h28;
    localparam logic [7:0] IDX_CTRL = 8'h29;
    localparam logic [7:0] IDX_STATE = 8'h2A;

    // ----------------
    // Field positions
    // ----------------
    localparam int FLAG_HI = 15;
    localparam int FLAG_LO = 10;
    localparam int POP_DIS_BIT = 5;
    localparam int POP_LEN_BIT = 4;
    localparam int CAP_HI = 15;
    localparam int CAP_LO = 9;
    localparam int NS_HI = 8;
    localparam int NS_LO = 6;
    localparam int SN_HI = 5;
    localparam int SN_LO = 3;
    localparam int CTRL_REQ_HI = 5;
    localparam int CTRL_CAP_MODE = 6;
    localparam int CTRL_MIC_EN = 7;
    localparam int CTRL_CELL_EN = 8;

    // ----------------
    // Reset values
    // ----------------
    localparam logic [5:0] FLAGS_RST = 6'h3F;
    localparam logic [6:0] CAP_RST = 7'h7F;
    localparam logic [2:0] DEB_RST = 3'h0;
    localparam logic [8:0] CTRL_RST = 9'h000;
    // Drivers taking pop sequencing: speaker a/b, handset, vground
    localparam logic [5:0] SEQ_MASK = 6'h3C;
    localparam logic [5:0] SPK_MASK = 6'h30;

    // ----------------
    // Cell cap codes
    // ----------------
    localparam logic [6:0] CELL_TOP_VALID = 7'h44;
    localparam logic [6:0] CELL_12DB = 7'h5D;

    // ----------------
    // Timing
    // ----------------
    localparam int CLK_MHZ = 100;
    localparam int HALF_MS_US = 500;
    localparam int HALF_MS_CYCLES = HALF_MS_US * CLK_MHZ;
    localparam int POP_SHORT_MS = 802;
    localparam int POP_LONG_MS = 4006;
    localparam int POP_CAPLESS_MS = 10;
    localparam logic [13:0] POP_SHORT_TICKS = 14'(POP_SHORT_MS * 2);
    localparam logic [13:0] POP_LONG_TICKS = 14'(POP_LONG_MS * 2);
    localparam logic [13:0] POP_CAPLESS_TICKS = 14'(POP_CAPLESS_MS * 2);

    // Debounce code to half-millisecond ticks; 110 taken as 32 ms
    function automatic logic [6:0] deb_ticks(input logic [2:0] code);
        logic [6:0] t;
        t = 7'h00;
        unique case (code)
            3'h0: t = 7'h00;
            3'h1: t = 7'h01;
            3'h2: t = 7'h02;
            3'h3: t = 7'h04;
            3'h4: t = 7'h08;
            3'h5: t = 7'h10;
            3'h6: t = 7'h40;
            3'h7: t = 7'h40;
        endcase
        return t;
    endfunction
endpackage

// File: design/dpagc_reg_if.sv
// Internal register access carrier between bus slave and register bank
`timescale 1ns/1ns
interface dpagc_reg_if;
    logic        wr;
    logic [7:0]  idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        hit;
    modport slave (output wr, idx, wdata, input rdata, hit);
    modport regs (input wr, idx, wdata, output rdata, hit);
endinterface

// File: design/dpagc_ahb_slave.sv
// AHB-Lite slave: zero-wait writes, one-wait reads
`timescale 1ns/1ns
module dpagc_ahb_slave (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    dpagc_reg_if.slave       bus
);
    typedef enum logic [1:0] {SL_IDLE, SL_WRITE, SL_RWAIT, SL_RDATA} dpagc_sl_e;
    typedef struct packed {
        dpagc_sl_e   ph;
        logic [7:0]  idx;
        logic [31:0] rdata;
    } dpagc_sl_s;
    dpagc_sl_s st_reg;
    dpagc_sl_s st_next;

    // ---------------------------------------------------------------
    // Phase tracking
    // ---------------------------------------------------------------
    // Reads wait one cycle so a write just before is always seen
    always_comb
    begin
        st_next = st_reg;
        if (st_reg.ph == SL_RWAIT)
        begin
            st_next.rdata = bus.hit ? {16'h0000, bus.rdata} : 32'h0000_0000;
            st_next.ph = SL_RDATA;
        end
        else if (i_hsel && i_htrans[1] && i_hready)
        begin
            st_next.idx = i_haddr[9:2];
            st_next.ph = i_hwrite ? SL_WRITE : SL_RWAIT;
        end
        else
        begin
            st_next.ph = SL_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st_reg <= '{ph: SL_IDLE, idx: 8'h00, rdata: 32'h0000_0000};
        else
            st_reg <= st_next;
    end

    // Response is always OKAY, unmapped reads give zero
    assign o_hreadyout = (st_reg.ph != SL_RWAIT);
    assign o_hrdata = st_reg.rdata;
    assign bus.wr = (st_reg.ph == SL_WRITE);
    assign bus.idx = st_reg.idx;
    assign bus.wdata = i_hwdata[15:0];
endmodule

// File: design/dpagc_agc_path.sv
// One AGC path: silence debounce and gain cap
`timescale 1ns/1ns
module dpagc_agc_path #(
    parameter bit CELL = 1'b0
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_tick,
    input  wire logic       i_below,
    input  wire logic       i_enable,
    input  wire logic [6:0] i_cap,
    input  wire logic [2:0] i_ns_code,
    input  wire logic [2:0] i_sn_code,
    input  wire logic [6:0] i_gain_req,
    output logic      [6:0] o_gain,
    output logic            o_silence
);
    typedef struct packed {
        logic       silent;
        logic [6:0] cnt;
        logic [6:0] gain;
    } dpagc_path_s;
    dpagc_path_s st_reg;
    dpagc_path_s st_next;
    logic [6:0] cap_eff;
    logic [6:0] req_eff;
    logic [6:0] limit;

    // ---------------------------------------------------------------
    // Cap normalising: invalid cell codes fold to the top valid step
    // ---------------------------------------------------------------
    always_comb
    begin
        cap_eff = i_cap;
        req_eff = i_gain_req;
        if (CELL)
        begin
            if (i_cap >= dpagc_pkg::CELL_12DB)
                cap_eff = dpagc_pkg::CELL_12DB; // RULE9
            else if (i_cap > dpagc_pkg::CELL_TOP_VALID)
                cap_eff = dpagc_pkg::CELL_TOP_VALID; // RULE9
            if (i_gain_req >= dpagc_pkg::CELL_12DB)
                req_eff = dpagc_pkg::CELL_12DB;
        end
        limit = (req_eff > cap_eff) ? cap_eff : req_eff; // RULE6 RULE12
    end

    // ---------------------------------------------------------------
    // Silence debounce and gain register
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.gain = i_enable ? limit : i_gain_req; // RULE12
        if (!i_enable)
        begin
            st_next.silent = 1'b0;
            st_next.cnt = 7'h00;
        end
        else if (st_reg.silent == i_below)
        begin
            st_next.cnt = 7'h00; // Level agrees with mode, restart
        end
        else if (st_reg.cnt >= dpagc_pkg::deb_ticks(st_reg.silent ? i_sn_code : i_ns_code))
        begin
            st_next.silent = i_below; // RULE7 RULE8 RULE10 RULE11
            st_next.cnt = 7'h00;
        end
        else if (i_tick)
        begin
            st_next.cnt = st_reg.cnt + 7'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st_reg <= '{silent: 1'b0, cnt: 7'h00, gain: 7'h00};
        else
            st_reg <= st_next;
    end

    assign o_gain = st_reg.gain;
    assign o_silence = st_reg.silent;
endmodule

// File: test/dpagc_chk.sv
// Checker of bus timing, gain not above request, short handling and silence entry
`timescale 1ns/1ns
module dpagc_chk (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic        i_short_detect,
    input wire logic        i_mic_below_thr,
    input wire logic        i_cell_below_thr,
    input wire logic [6:0]  i_mic_gain_req,
    input wire logic [6:0]  i_cell_gain_req,
    input wire logic [6:0]  o_mic_gain,
    input wire logic [6:0]  o_cell_gain,
    input wire logic        o_mic_silence,
    input wire logic        o_cell_silence,
    input wire logic [5:0]  o_drv_enable
);
    // ----------------
    // Properties, one clock domain
    // ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    bus_okay_a: assert property (o_hresp == 1'b0) else $error("response not okay");
    rd_wait_a: assert property (i_hsel && i_htrans[1] && i_hready && !i_hwrite
        |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait state wrong");
    wr_nowait_a: assert property (i_hsel && i_htrans[1] && i_hready && i_hwrite
        |=> o_hreadyout) else $error("write stalled");
    upper_zero_a: assert property (o_hreadyout |-> o_hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    mic_cap_a: assert property (o_mic_gain <= $past(i_mic_gain_req))
        else $error("mic gain above request");
    cell_cap_a: assert property ($past(i_cell_gain_req) <= 7'h5D
        |-> o_cell_gain <= $past(i_cell_gain_req)) else $error("cell gain above request");
    // Six cycles: synchroniser plus forcing flop
    short_off_a: assert property (i_short_detect [*6] |=> o_drv_enable == 6'h00)
        else $error("drivers on during short");
    mic_sil_a: assert property ($rose(o_mic_silence) |-> $past(i_mic_below_thr))
        else $error("mic silence without low input");
    cell_sil_a: assert property ($rose(o_cell_silence) |-> $past(i_cell_below_thr))
        else $error("cell silence without low input");
endmodule
bind dpagc_top dpagc_chk u_chk (.*);

// File: test/testbench.sv
// Self-checking bench of the driver status and AGC limit registers
`timescale 1ns/1ns
module testbench;
    logic i_clk, i_reset_n, i_hsel, i_hwrite, i_short_detect, i_mic_below_thr, i_cell_below_thr;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, q;
    logic [1:0]  i_htrans;
    logic [6:0]  i_mic_gain_req, i_cell_gain_req, o_mic_gain, o_cell_gain, mc, cc, mr, cr;
    logic [5:0]  o_drv_enable;
    logic        o_hreadyout, o_hresp, o_mic_silence, o_cell_silence, o_pop_busy;
    logic [15:0] w;
    int          n_fail = 0, samples_checked = 0, cyc = 0, seed = 25225, n, nm, nc;
    // Ten-cycle tick keeps pops short
    dpagc_top #(.HALF_MS_CYCLES(10)) dut (.*, .i_hsize(3'h2), .i_hready(o_hreadyout));
    // ----------------
    // Tasks and reference model
    // ----------------
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One AHB transfer; hready looked at where settled
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
        i_hsel <= 1'b1; i_htrans <= 2'h2; i_hwrite <= wr; i_haddr <= {22'h0, idx, 2'h0};
        do @(negedge i_clk); while (o_hreadyout !== 1'b1);
        @(posedge i_clk);
        i_hsel <= 1'b0; i_htrans <= 2'h0; i_hwdata <= {16'h0, d};
        do @(negedge i_clk); while (o_hreadyout !== 1'b1);
        q = o_hrdata;
        @(posedge i_clk);
    endtask
    // Cell cap per the code map
    function automatic logic [6:0] cell_exp(input logic [6:0] r, input logic [6:0] c);
        logic [6:0] k;
        k = (c >= 7'h5D) ? 7'h5D : ((c > 7'h44) ? 7'h44 : c);
        r = (r >= 7'h5D) ? 7'h5D : r;
        return (r < k) ? r : k;
    endfunction
    // Wait for masked drivers
    task automatic wait_drv(input logic [5:0] m);
        n = 0;
        while ((o_drv_enable & m) !== m && n < 20000)
        begin
            @(negedge i_clk);
            n++;
        end
        @(posedge i_clk);
    endtask
    // ----------------
    // Clock, reset and watchdog
    // ----------------
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        if (++cyc == 40000)
        begin
            n_fail++;
            final_report();
        end
    end
    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        {i_reset_n, i_hsel, i_hwrite, i_short_detect, i_mic_below_thr, i_cell_below_thr} = '0;
        {i_haddr, i_hwdata, i_htrans, i_mic_gain_req, i_cell_gain_req} = '0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        bus(0, 8'h25, 0); cmp(q, 32'h0000FC00);
        bus(0, 8'h26, 0); cmp(q, 32'h0000FE00);
        bus(0, 8'h28, 0); cmp(q, 32'h0000FE00);
        // Random writes; reserved bits read zero
        repeat (4)
        begin
            w = 16'($random(seed));
            bus(1, 8'h25, w); bus(0, 8'h25, 0); cmp(q, {16'h0, 16'hFC00 | (w & 16'h0030)});
            bus(1, 8'h26, w); bus(0, 8'h26, 0); cmp(q, {16'h0, w & 16'hFFF8});
            bus(1, 8'h28, w); bus(0, 8'h28, 0); cmp(q, {16'h0, w & 16'hFFF8});
            bus(1, 8'h30, w); bus(0, 8'h30, 0); cmp(q, 32'h0);
        end
        // Both AGC loops on, random caps and requests
        bus(1, 8'h29, 16'h0180);
        repeat (12)
        begin
            {mc, cc, mr, cr} = 28'($random(seed));
            bus(1, 8'h26, {mc, 9'h0}); bus(1, 8'h28, {cc, 9'h0});
            i_mic_gain_req <= mr; i_cell_gain_req <= cr;
            @(posedge i_clk); @(posedge i_clk); @(negedge i_clk);
            cmp(o_mic_gain, (mr < mc) ? mr : mc);
            cmp(o_cell_gain, cell_exp(cr, cc));
            @(posedge i_clk);
        end
        // Silence: mic 4 ticks, cell 8 ticks
        bus(1, 8'h26, 16'h00C0); bus(1, 8'h28, 16'h0100);
        i_mic_below_thr <= 1'b1; i_cell_below_thr <= 1'b1;
        {n, nm, nc} = '0;
        while (n < 200)
        begin
            @(negedge i_clk);
            n++;
            if (o_mic_silence !== 1'b1) nm = n;
            if (o_cell_silence !== 1'b1) nc = n;
        end
        cmp(32'(nm >= 30 && nm <= 52), 32'h1);
        cmp(32'(nc >= 70 && nc <= 92), 32'h1);
        @(posedge i_clk);
        i_mic_below_thr <= 1'b0; i_cell_below_thr <= 1'b0;
        repeat (4) @(negedge i_clk);
        cmp({o_mic_silence, o_cell_silence}, 32'h0);
        @(posedge i_clk);
        // Twenty-tick pop, then flags clear
        bus(1, 8'h25, 16'h0000); bus(1, 8'h29, 16'h003F);
        repeat (2) @(negedge i_clk); cmp(o_pop_busy, 32'h1);
        wait_drv(6'h3C); cmp(32'(n >= 190 && n <= 215), 32'h1);
        bus(0, 8'h25, 0); cmp(q, 32'h0);
        // Cap-coupled speakers, short length
        bus(1, 8'h29, 16'h0000); bus(1, 8'h29, 16'h0070);
        wait_drv(6'h30); cmp(32'(n >= 16030 && n <= 16065), 32'h1);
        // Sequencing off grants at once
        bus(1, 8'h25, 16'h0020); bus(1, 8'h29, 16'h0000); bus(1, 8'h29, 16'h003C);
        wait_drv(6'h3C); cmp(32'(n <= 4), 32'h1);
        // Short: drivers off, flags set
        i_short_detect <= 1'b1;
        repeat (8) @(negedge i_clk);
        cmp(o_drv_enable, 32'h0); @(posedge i_clk);
        bus(0, 8'h25, 0); cmp(q, 32'h0000FC20);
        i_short_detect <= 1'b0;
        final_report();
    end
endmodule
